// ==== rtl/flash_cfg_pkg.sv ====
package flash_cfg_pkg;

    // Command codes
    localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_WRITE_LATCH_CLR = 8'h04;
    localparam logic [7:0] OP_STATUS_READ     = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE    = 8'h01;
    localparam logic [7:0] OP_FUNC_WRITE      = 8'h42;
    localparam logic [7:0] OP_FUNC_READ       = 8'h48;
    localparam logic [7:0] OP_PARAMS_SET      = 8'hc0;
    localparam logic [7:0] OP_PARAMS_READ     = 8'h61;
    localparam logic [7:0] OP_PAGE_PROG       = 8'h02;
    localparam logic [7:0] OP_PAGE_PROG_Q1    = 8'h32;
    localparam logic [7:0] OP_PAGE_PROG_Q2    = 8'h38;
    localparam logic [7:0] OP_SECT_ERASE_A    = 8'hd7;
    localparam logic [7:0] OP_SECT_ERASE_B    = 8'h20;
    localparam logic [7:0] OP_BLK32_ERASE     = 8'h52;
    localparam logic [7:0] OP_BLK64_ERASE     = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE_A    = 8'hc7;
    localparam logic [7:0] OP_CHIP_ERASE_B    = 8'h60;
    localparam logic [7:0] OP_INFO_PROG       = 8'h62;
    localparam logic [7:0] OP_INFO_ERASE      = 8'h64;
    localparam logic [7:0] OP_RD_NORMAL       = 8'h03;
    localparam logic [7:0] OP_RD_FAST         = 8'h0b;
    localparam logic [7:0] OP_RD_DTR          = 8'h0d;
    localparam logic [7:0] OP_RD_DUAL_OUT     = 8'h3b;
    localparam logic [7:0] OP_RD_QUAD_OUT     = 8'h6b;
    localparam logic [7:0] OP_RD_DUAL_IO      = 8'hbb;
    localparam logic [7:0] OP_RD_DUAL_DTR     = 8'hbd;
    localparam logic [7:0] OP_RD_QUAD_IO      = 8'heb;
    localparam logic [7:0] OP_RD_QUAD_DTR     = 8'hed;

    // Frame bit counts at which fields are complete
    localparam logic [5:0] BITS_OPCODE = 6'h08;
    localparam logic [5:0] BITS_DATA   = 6'h10;
    localparam logic [5:0] BITS_ADDR   = 6'h20;

    // Status register fields
    localparam int ST_LOCK  = 7;
    localparam int ST_QE    = 6;
    localparam int ST_BP_HI = 5;
    localparam int ST_BP_LO = 2;
    localparam int ST_WEL   = 1;
    localparam int ST_WIP   = 0;

    // Function register fields
    localparam int FN_BOTTOM = 1;
    localparam int FN_PROGRAM_PAUSED_FLAG   = 2;
    localparam int FN_ERASE_PAUSED_FLAG   = 3;
    localparam logic [7:0] FN_OTP_MASK = 8'hf2;

    // Read parameter fields and reset value
    localparam logic [7:0] RP_RESET   = 8'he0;
    localparam int         RP_WRAP_EN = 2;

    // Info-row select lives in these address bits
    localparam int INFO_ROW_HI = 13;
    localparam int INFO_ROW_LO = 12;

    // Array operation kinds handed to the core
    typedef enum logic [2:0] {
        KIND_PROGRAM    = 3'b000,
        KIND_SECTOR     = 3'b001,
        KIND_BLOCK32    = 3'b010,
        KIND_BLOCK64    = 3'b011,
        KIND_CHIP       = 3'b100,
        KIND_INFO_PROG  = 3'b101,
        KIND_INFO_ERASE = 3'b110,
        KIND_NONE       = 3'b111
    } array_kind_t;

endpackage

// ==== rtl/flash_cfg_regs.sv ====
`timescale 1ns/1ns
// Summary of operation
// - Program or erase into the protected block range is refused.
// - Whole-array erase is ignored unless all protect-level bits are zero.
// - Lock set with write-protect pin low: status write ignored, fields read-only.
// - Lock clear or write-protect pin high: status write updates protection fields.
// - Quad enable 0: pins are write-protect and hold; 1: pins are IO2/IO3.
// - Top levels 1..7 protect 2^(level-1) 64 KB blocks ending at block 127.
// - Top protect-level bit set protects all 128 blocks regardless of others.
// - Bottom select applies range from block 0 up; cannot return to top.
// - One-time-programmable function bits stay 1 once written to 1.
// - Program-paused flag sets on suspend during program, clears on resume.
// - Erase-paused flag sets on suspend during erase, clears on resume.
// - Info-row lock bits default 0; once 1 they block that row's programming.
// - Read-parameters-set command loads all eight read parameter bits.
// - Drive strength 7:5, dummy select 4:3, wrap enable 2; reset 8'he0.
// - Burst codes give 8/16/32/64 bytes; wrap enable selects wrap or sequential.
// - QPI fast read and quad I/O read: codes give 6/4/8/10 dummy cycles.
// - Other reads: quad DTR 3/2/4/5, dual DTR 2/2/4/4, dual I/O 4/4/8/8, fixed ones.
// - Writes need the write latch set first; read-parameter set is exempt.
// - Register reads repeat the same byte until chip select rises.
// - Lock, quad enable and protect level reset to 0, changed only by status write.
module flash_cfg_regs (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic        si,
    input  wire logic        wp_n_io2_in,
    input  wire logic        hold_n_io3_in,
    input  wire logic        qpi_mode,
    input  wire logic        core_busy,
    input  wire logic        program_active,
    input  wire logic        erase_active,
    input  wire logic        suspend_req,
    input  wire logic        resume_req,
    output logic             so_out,
    output logic             so_oe_n,
    output logic             quad_io_enable,
    output logic             hold_active,
    output logic [2:0]       drive_strength,
    output logic             wrap_enable,
    output logic [6:0]       wrap_bytes,
    output logic [3:0]       read_dummy,
    output logic             write_latch,
    output logic             array_go,
    output logic             array_refused,
    output logic [2:0]       array_kind,
    output logic [22:0]      array_addr
);

    // Protection check on one 64 KB block index
    function automatic logic blk_protected(input logic [6:0] blk, input logic [3:0] level,
                                           input logic bottom);
        logic [7:0] span;
        span = 8'h01 << level[2:0];
        span = span >> 1;
        if (level == 4'h0) begin
            blk_protected = 1'b0;
        end else if (level[3]) begin
            blk_protected = 1'b1;
        end else if (bottom) begin
            blk_protected = {1'b0, blk} < span;
        end else begin
            blk_protected = {1'b0, blk} >= (8'h80 - span);
        end
    endfunction

    // Dummy cycles for a read opcode and dummy select code
    function automatic logic [3:0] dummy_for(input logic [7:0] op, input logic qpi,
                                             input logic [1:0] code);
        logic [3:0] q;
        logic [3:0] d;
        // Double-rate quad steps 3/2/4/5, which no simple sum of the code gives
        d = code[1] ? {3'b010, code[0]} : {3'b001, ~code[0]};
        case (code)
            2'b00:   q = 4'h6;
            2'b01:   q = 4'h4;
            2'b10:   q = 4'h8;
            default: q = 4'ha;
        endcase
        case (op)
            // QPI fast read and quad I/O
            flash_cfg_pkg::OP_RD_FAST:     dummy_for = qpi ? q : 4'h8;
            flash_cfg_pkg::OP_RD_QUAD_IO:  dummy_for = q;
            flash_cfg_pkg::OP_RD_DTR:      dummy_for = qpi ? d : 4'h4;
            flash_cfg_pkg::OP_RD_QUAD_DTR: dummy_for = d;
            flash_cfg_pkg::OP_RD_DUAL_DTR: dummy_for = code[1] ? 4'h4 : 4'h2;
            flash_cfg_pkg::OP_RD_DUAL_IO:  dummy_for = code[1] ? 4'h8 : 4'h4;
            flash_cfg_pkg::OP_RD_DUAL_OUT: dummy_for = 4'h8;
            flash_cfg_pkg::OP_RD_QUAD_OUT: dummy_for = 4'h8;
            default:                       dummy_for = 4'h0;
        endcase
    endfunction

    // Link pins, two stages each plus a history stage for edges
    logic [1:0] sck_q;
    logic       sck_prev_q;
    logic [1:0] cs_q;
    logic       cs_prev_q;
    logic [1:0] si_q;
    logic [1:0] wp_q;
    logic [1:0] hold_q;

    // Frame state
    logic [5:0]  cnt_q;
    logic [5:0]  cnt_d;
    logic [23:0] sh_q;
    logic [23:0] sh_d;
    logic [7:0]  op_q;
    logic [7:0]  data_q;
    logic [22:0] addr_q;
    logic [2:0]  out_idx_q;

    // Registers
    logic [7:0] status_q;
    logic [7:0] func_q;
    logic [7:0] params_q;
    logic       wel_q;

    // Output flops
    logic        so_q;
    logic        so_oe_n_q;
    logic        hold_q_out;
    logic [3:0]  dummy_q;
    logic        go_q;
    logic        refused_q;
    logic [2:0]  kind_q;
    logic [22:0] out_addr_q;

    // Two-flop synchronisers; first stage feeds only the second
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sck_q      <= 2'b00;
            sck_prev_q <= 1'b0;
            cs_q       <= 2'b11;
            cs_prev_q  <= 1'b1;
            si_q       <= 2'b00;
            wp_q       <= 2'b11;
            hold_q     <= 2'b11;
        end else begin
            sck_q      <= {sck_q[0], sck};
            sck_prev_q <= sck_q[1];
            cs_q       <= {cs_q[0], cs_n};
            cs_prev_q  <= cs_q[1];
            si_q       <= {si_q[0], si};
            wp_q       <= {wp_q[0], wp_n_io2_in};
            hold_q     <= {hold_q[0], hold_n_io3_in};
        end
    end

    // Pin functions and edge detection
    // control pins only while quad enable is clear
    wire qe         = status_q[flash_cfg_pkg::ST_QE];
    wire wp_low     = ~qe & ~wp_q[1];
    wire hold_on    = ~qe & ~hold_q[1];
    wire cs_active  = ~cs_q[1];
    wire sck_rise   = cs_active & ~hold_on & sck_q[1] & ~sck_prev_q;
    wire sck_fall   = cs_active & ~hold_on & ~sck_q[1] & sck_prev_q;
    wire cs_rise    = cs_q[1] & ~cs_prev_q;
    wire [7:0] byte_in = {sh_q[6:0], si_q[1]};

    // Command decode, evaluated at chip select rise
    wire [3:0] level     = status_q[flash_cfg_pkg::ST_BP_HI:flash_cfg_pkg::ST_BP_LO];
    wire       bottom    = func_q[flash_cfg_pkg::FN_BOTTOM];
    wire       has_data  = cnt_q >= flash_cfg_pkg::BITS_DATA;
    wire       has_addr  = cnt_q >= flash_cfg_pkg::BITS_ADDR;
    wire       is_prog   = (op_q == flash_cfg_pkg::OP_PAGE_PROG) | (op_q == flash_cfg_pkg::OP_PAGE_PROG_Q1)
                           | (op_q == flash_cfg_pkg::OP_PAGE_PROG_Q2);
    wire       is_sect   = (op_q == flash_cfg_pkg::OP_SECT_ERASE_A) | (op_q == flash_cfg_pkg::OP_SECT_ERASE_B);
    wire       is_b32    = op_q == flash_cfg_pkg::OP_BLK32_ERASE;
    wire       is_b64    = op_q == flash_cfg_pkg::OP_BLK64_ERASE;
    wire       is_chip   = (op_q == flash_cfg_pkg::OP_CHIP_ERASE_A) | (op_q == flash_cfg_pkg::OP_CHIP_ERASE_B);
    wire       is_iprog  = op_q == flash_cfg_pkg::OP_INFO_PROG;
    wire       is_ierase = op_q == flash_cfg_pkg::OP_INFO_ERASE;
    wire       addr_op   = is_prog | is_sect | is_b32 | is_b64 | is_iprog | is_ierase;
    wire       array_op  = (addr_op & has_addr) | (is_chip & cnt_q == flash_cfg_pkg::BITS_OPCODE);
    wire [1:0] row_sel   = addr_q[flash_cfg_pkg::INFO_ROW_HI:flash_cfg_pkg::INFO_ROW_LO];
    wire       row_lock  = func_q[3'd4 + {1'b0, row_sel}];

    // block index from the upper address bits
    wire       blk_prot  = blk_protected(addr_q[22:16], level, bottom);

    // protected range, chip erase needs level 0, locked rows
    wire       prot_hit  = ((is_prog | is_sect | is_b32 | is_b64) & blk_prot)
                           | (is_chip & level != 4'h0) | (is_iprog & row_lock);

    // writes need the latch and an idle core
    wire       may_write = wel_q & ~core_busy;

    // lock with pin low blocks status writes; otherwise allowed
    wire       st_locked = status_q[flash_cfg_pkg::ST_LOCK] & wp_low;
    wire       do_st_wr  = cs_rise & (op_q == flash_cfg_pkg::OP_STATUS_WRITE) & has_data & may_write & ~st_locked;
    wire       do_fn_wr  = cs_rise & (op_q == flash_cfg_pkg::OP_FUNC_WRITE) & has_data & may_write;
    wire       do_rp_wr  = cs_rise & (op_q == flash_cfg_pkg::OP_PARAMS_SET) & has_data;
    wire       do_go     = cs_rise & array_op & may_write & ~prot_hit;
    wire       do_refuse = cs_rise & array_op & ~(may_write & ~prot_hit);

    // Register read selection; live value so status reflects current state
    wire [7:0] status_rd = {status_q[7:2], wel_q, core_busy};
    wire       is_rd_reg = (op_q == flash_cfg_pkg::OP_STATUS_READ) | (op_q == flash_cfg_pkg::OP_FUNC_READ)
                           | (op_q == flash_cfg_pkg::OP_PARAMS_READ);
    wire [7:0] rd_byte   = (op_q == flash_cfg_pkg::OP_STATUS_READ) ? status_rd :
                           (op_q == flash_cfg_pkg::OP_FUNC_READ)   ? func_q : params_q;
    wire       reading   = is_rd_reg & (cnt_q >= flash_cfg_pkg::BITS_OPCODE);

    // Shift and count on link rising edges; a new frame starts from zero
    always_comb begin
        cnt_d = cnt_q;
        sh_d  = sh_q;
        if (!cs_active) begin
            cnt_d = 6'h00;
        end else if (sck_rise) begin
            sh_d = {sh_q[22:0], si_q[1]};
            if (cnt_q != 6'h3f) begin
                cnt_d = cnt_q + 6'h01;  // Saturates; long program data is not counted
            end
        end
    end

    // Frame capture
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_q  <= 6'h00;
            sh_q   <= 24'h000000;
            op_q   <= 8'h00;
            data_q <= 8'h00;
            addr_q <= 23'h000000;
        end else begin
            cnt_q <= cnt_d;
            sh_q  <= sh_d;
            if (sck_rise && cnt_q == flash_cfg_pkg::BITS_OPCODE - 6'h01) begin
                op_q <= byte_in;
            end
            if (sck_rise && cnt_q == flash_cfg_pkg::BITS_DATA - 6'h01) begin
                data_q <= byte_in;
            end
            if (sck_rise && cnt_q == flash_cfg_pkg::BITS_ADDR - 6'h01) begin
                addr_q <= {sh_q[21:0], si_q[1]};
            end
        end
    end

    // Write latch; a set arriving with an executed write wins
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wel_q <= 1'b0;
        end else if (cs_rise && op_q == flash_cfg_pkg::OP_WRITE_LATCH_SET) begin
            wel_q <= 1'b1;
        end else if ((cs_rise && op_q == flash_cfg_pkg::OP_WRITE_LATCH_CLR) || do_st_wr || do_fn_wr || do_go) begin
            wel_q <= 1'b0;
        end
    end

    // Status register; no stored copy survives power, so reset is the factory zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            status_q <= 8'h00;
        // only the status write touches these bits
        end else if (do_st_wr) begin
            status_q <= {data_q[7:2], 2'b00};
        end
    end

    // Function register; suspend flags set over clear if both land together
    always_ff @(posedge clk) begin
        if (!rstn) begin
            func_q <= 8'h00;
        end else begin
            // one-time bits only ever gain ones; bit 0 stays zero
            if (do_fn_wr) begin
                func_q[7:4] <= func_q[7:4] | (data_q[7:4] & flash_cfg_pkg::FN_OTP_MASK[7:4]);
                func_q[1]   <= func_q[1] | data_q[1];
            end
            if (suspend_req && program_active) begin
                func_q[flash_cfg_pkg::FN_PROGRAM_PAUSED_FLAG] <= 1'b1;
            end else if (resume_req) begin
                func_q[flash_cfg_pkg::FN_PROGRAM_PAUSED_FLAG] <= 1'b0;
            end
            if (suspend_req && erase_active) begin
                func_q[flash_cfg_pkg::FN_ERASE_PAUSED_FLAG] <= 1'b1;
            end else if (resume_req) begin
                func_q[flash_cfg_pkg::FN_ERASE_PAUSED_FLAG] <= 1'b0;
            end
            func_q[0] <= 1'b0;
        end
    end

    // Read parameters, volatile
    always_ff @(posedge clk) begin
        if (!rstn) begin
            params_q <= flash_cfg_pkg::RP_RESET;
        // all eight bits from the data byte
        end else if (do_rp_wr) begin
            params_q <= data_q;
        end
    end

    // Register read-out on falling link edges
    always_ff @(posedge clk) begin
        if (!rstn) begin
            out_idx_q <= 3'h7;
            so_q      <= 1'b0;
            so_oe_n_q <= 1'b1;
        end else if (!cs_active) begin
            out_idx_q <= 3'h7;
            so_oe_n_q <= 1'b1;
        end else if (sck_fall && reading) begin
            // index wraps so the same byte repeats
            so_q      <= rd_byte[out_idx_q];
            out_idx_q <= out_idx_q - 3'h1;
            so_oe_n_q <= 1'b0;
        end
    end

    // Core hand-off and read configuration outputs
    always_ff @(posedge clk) begin
        if (!rstn) begin
            go_q       <= 1'b0;
            refused_q  <= 1'b0;
            kind_q     <= flash_cfg_pkg::KIND_NONE;
            out_addr_q <= 23'h000000;
            dummy_q    <= 4'h0;
            hold_q_out <= 1'b0;
        end else begin
            go_q       <= do_go;
            refused_q  <= do_refuse;
            hold_q_out <= hold_on;
            if (do_go) begin
                out_addr_q <= addr_q;
                kind_q     <= is_prog   ? flash_cfg_pkg::KIND_PROGRAM :
                              is_sect   ? flash_cfg_pkg::KIND_SECTOR :
                              is_b32    ? flash_cfg_pkg::KIND_BLOCK32 :
                              is_b64    ? flash_cfg_pkg::KIND_BLOCK64 :
                              is_chip   ? flash_cfg_pkg::KIND_CHIP :
                              is_iprog  ? flash_cfg_pkg::KIND_INFO_PROG : flash_cfg_pkg::KIND_INFO_ERASE;
            end
            // dummy count follows the opcode just taken
            dummy_q <= dummy_for(op_q, qpi_mode, params_q[4:3]);
        end
    end

    // read parameter fields straight from their flop
    assign drive_strength = params_q[7:5];
    assign wrap_enable    = params_q[flash_cfg_pkg::RP_WRAP_EN];
    assign wrap_bytes     = 7'h08 << params_q[1:0];
    assign quad_io_enable = status_q[flash_cfg_pkg::ST_QE];
    assign write_latch    = wel_q;
    assign hold_active    = hold_q_out;
    assign read_dummy     = dummy_q;
    assign so_out         = so_q;
    assign so_oe_n        = so_oe_n_q;
    assign array_go       = go_q;
    assign array_refused  = refused_q;
    assign array_kind     = kind_q;
    assign array_addr     = out_addr_q;

endmodule

// ==== dv/flash_cfg_regs_assertions.sv ====
`timescale 1ns/1ns
module flash_cfg_checker (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       cs_n,
    input wire logic       hold_n_io3_in,
    input wire logic       quad_io_enable,
    input wire logic       hold_active,
    input wire logic       so_oe_n,
    input wire logic [2:0] drive_strength,
    input wire logic [6:0] wrap_bytes,
    input wire logic       write_latch,
    input wire logic       array_go,
    input wire logic       array_refused
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Decisions on array operations are exclusive; go is a single pulse
    property p_go_excl; !(array_go && array_refused); endproperty
    a_go_excl: assert property (p_go_excl) else $error("go and refused together");
    property p_go_pulse; array_go |=> !array_go; endproperty
    a_go_pulse: assert property (p_go_pulse) else $error("go longer than one cycle");
    // Commands only act once the frame has closed
    property p_op_after_cs; (array_go || array_refused) |-> cs_n && $past(cs_n, 3); endproperty
    a_op_after_cs: assert property (p_op_after_cs) else $error("array decision inside a frame");
    property p_latch_cs; $changed(write_latch) |-> cs_n; endproperty
    a_latch_cs: assert property (p_latch_cs) else $error("latch moved inside a frame");
    property p_qe_cs; $changed(quad_io_enable) |-> cs_n; endproperty
    a_qe_cs: assert property (p_qe_cs) else $error("quad enable moved inside a frame");
    property p_params_cs; $changed({drive_strength, wrap_bytes}) |-> cs_n; endproperty
    a_params_cs: assert property (p_params_cs) else $error("read params moved inside a frame");
    property p_wrap_len; wrap_bytes inside {7'h08, 7'h10, 7'h20, 7'h40}; endproperty
    a_wrap_len: assert property (p_wrap_len) else $error("illegal wrap length");
    // Pin is hold only while quad enable is off; allow the synchroniser latency
    property p_hold_pin; (!quad_io_enable && !hold_n_io3_in) [*6] |-> hold_active; endproperty
    a_hold_pin: assert property (p_hold_pin) else $error("hold pin not honoured");
    property p_hold_qe; quad_io_enable [*4] |-> !hold_active; endproperty
    a_hold_qe: assert property (p_hold_qe) else $error("hold active with quad enable");
    property p_oe_idle; cs_n [*6] |-> so_oe_n; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("output driven while deselected");
endmodule
bind flash_cfg_regs flash_cfg_checker flash_cfg_checker_i (.clk, .rstn, .cs_n, .hold_n_io3_in,
    .quad_io_enable, .hold_active, .so_oe_n, .drive_strength, .wrap_bytes, .write_latch,
    .array_go, .array_refused);

// ==== dv/spi_host_model.sv ====
`timescale 1ns/1ns
// Host end of the serial link, mode 0; the clock parks low between frames
module spi_host_model (
    input  wire logic clk,
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    input  wire logic so_out
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // MSB first; 20 clk per half period gives the 160 ns link clock
    task automatic xfer(input logic [31:0] b, input int n, output logic [15:0] r);
        r = 16'h0;
        @(posedge clk) #1 cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            si = b[31-i];
            repeat (20) @(posedge clk);
            #1 sck = 1'b1;
            r = {r[14:0], so_out};
            repeat (20) @(posedge clk);
            #1 sck = 1'b0;
        end
        repeat (20) @(posedge clk);
        #1 cs_n = 1'b1;
        // Released data line shows the inverse, never a stale bit
        si = ~si;
        // Long enough for the command to execute and its pulse to be seen
        repeat (10) @(posedge clk);
    endtask
endmodule

// ==== dv/flash_cfg_regs_test.sv ====
`timescale 1ns/1ns
module flash_cfg_regs_test;
    logic        clk = 1'b0, rstn = 1'b0, sck, cs_n, si, so_out, so_oe_n, quad_io_enable, hold_active;
    logic        wp_n_io2_in = 1'b1, hold_n_io3_in = 1'b1, qpi_mode = 1'b0, core_busy = 1'b0;
    logic        program_active = 1'b0, erase_active = 1'b0, suspend_req = 1'b0, resume_req = 1'b0;
    logic        wrap_enable, write_latch, array_go, array_refused;
    logic [2:0]  drive_strength, array_kind, kind_seen;
    logic [6:0]  wrap_bytes;
    logic [3:0]  read_dummy;
    logic [22:0] array_addr, addr_seen;
    int          failures = 0, checked = 0, go_n = 0, rf_n = 0, lo;
    logic [7:0]  ops [4] = '{8'h02, 8'h20, 8'h52, 8'hd8};
    // Opcode, QPI flag, dummy count per code packed as nibbles
    logic [24:0] dq [9] = '{{8'heb, 1'b0, 16'ha846}, {8'hed, 1'b0, 16'h5423}, {8'hbd, 1'b0, 16'h4422},
        {8'hbb, 1'b0, 16'h8844}, {8'h03, 1'b0, 16'h0000}, {8'h0b, 1'b0, 16'h8888},
        {8'h0d, 1'b0, 16'h4444}, {8'h0b, 1'b1, 16'ha846}, {8'h0d, 1'b1, 16'h5423}};
    always #2 clk = ~clk;
    flash_cfg_regs flash_cfg_regs_i (.clk, .rstn, .sck, .cs_n, .si, .wp_n_io2_in, .hold_n_io3_in,
        .qpi_mode, .core_busy, .program_active, .erase_active, .suspend_req, .resume_req, .so_out,
        .so_oe_n, .quad_io_enable, .hold_active, .drive_strength, .wrap_enable, .wrap_bytes,
        .read_dummy, .write_latch, .array_go, .array_refused, .array_kind, .array_addr);
    spi_host_model spi_host_model_i (.clk, .sck, .cs_n, .si, .so_out);
    // Count decision pulses; kind is captured in the pulse cycle
    always @(posedge clk) begin
        if (array_go === 1'b1) begin
            go_n++;
            kind_seen = array_kind;
            addr_seen = array_addr;
        end
        if (array_refused === 1'b1) rf_n++;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic frame(input logic [31:0] b, input int n);
        logic [15:0] r;
        spi_host_model_i.xfer(b, n, r);
    endtask
    // Two bytes after the opcode: the same register byte must come twice
    task automatic rd(input logic [7:0] op, input logic [7:0] exp);
        logic [15:0] r;
        spi_host_model_i.xfer({op, 24'h0}, 24, r);
        chk("register read", r, {exp, exp});
    endtask
    task automatic wr(input logic [7:0] op, input logic [7:0] d);
        frame({8'h06, 24'h0}, 8);
        frame({op, d, 16'h0}, 16);
    endtask
    task automatic op(input logic [7:0] c, input logic [22:0] a, input logic g, input logic [2:0] k);
        int g0, r0;
        g0 = go_n;
        r0 = rf_n;
        frame({8'h06, 24'h0}, 8);
        frame({c, 1'b0, a}, (c == 8'hc7 || c == 8'h60) ? 8 : 32);
        chk("accepted", go_n - g0, g);
        chk("refused", rf_n - r0, !g);
        if (g) chk("kind", kind_seen, k);
        if (g && k != 3'h4) chk("address", addr_seen, a);
    endtask
    task automatic complete_run;
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        complete_run;
    end
    initial begin
        repeat (2) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (5) @(posedge clk);
        rd(8'h05, 8'h00);
        rd(8'h48, 8'h00);
        rd(8'h61, 8'he0);
        chk("params", {drive_strength, wrap_enable, wrap_bytes}, {3'h7, 1'b0, 7'h08});
        // Every dummy code against every read opcode except dual and quad output, no latch needed
        for (int c = 0; c < 4; c++) begin
            frame({8'hc0, 3'h5, c[1:0], 1'b1, c[1:0], 16'h0}, 16);
            chk("params", {drive_strength, wrap_enable, wrap_bytes}, {3'h5, 1'b1, 7'h08 << c});
            for (int i = 0; i < 9; i++) begin
                #1 qpi_mode = dq[i][16];
                frame({dq[i][24:17], 24'h0}, 8);
                chk("dummy", read_dummy, dq[i][4*c +: 4]);
            end
        end
        frame({8'h01, 8'h3c, 16'h0}, 16);
        rd(8'h05, 8'h00);
        // Top selection: last free block and first protected block per level
        for (int lv = 0; lv < 9; lv++) begin
            lo = lv == 0 ? 128 : lv == 8 ? 0 : 128 - (1 << (lv - 1));
            wr(8'h01, {2'b00, lv[3:0], 2'b00});
            rd(8'h05, {2'b00, lv[3:0], 2'b00});
            if (lo > 0) op(ops[lv % 4], {lo[6:0] - 7'h1, 16'hfff0}, 1'b1, {1'b0, lv[1:0]});
            if (lo < 128) op(ops[lv % 4], {lo[6:0], 16'h0010}, 1'b0, 3'h0);
        end
        op(8'hc7, 23'h0, 1'b0, 3'h0);
        wr(8'h01, 8'h00);
        op(8'h60, 23'h0, 1'b1, 3'h4);
        wr(8'h42, 8'h10);
        op(8'h62, 23'h000000, 1'b0, 3'h0);
        op(8'h62, 23'h001000, 1'b1, 3'h5);
        wr(8'h42, 8'h02);
        wr(8'h42, 8'h01);
        rd(8'h48, 8'h12);
        wr(8'h01, 8'h08);
        op(8'hd8, {7'h01, 16'hffff}, 1'b0, 3'h0);
        op(8'hd8, {7'h02, 16'h0000}, 1'b1, 3'h3);
        wr(8'h01, 8'h88);
        #1 wp_n_io2_in = 1'b0;
        wr(8'h01, 8'h00);
        rd(8'h05, 8'h8a);
        chk("latch", write_latch, 1'b1);
        #1 wp_n_io2_in = 1'b1;
        wr(8'h01, 8'h40);
        rd(8'h05, 8'h40);
        chk("quad enable", quad_io_enable, 1'b1);
        #1 hold_n_io3_in = 1'b0;
        repeat (10) @(posedge clk);
        chk("hold", hold_active, 1'b0);
        #1 hold_n_io3_in = 1'b1;
        // Pins used as hold again, so quad enable goes back off first
        wr(8'h01, 8'h00);
        #1 hold_n_io3_in = 1'b0;
        repeat (10) @(posedge clk);
        chk("hold", hold_active, 1'b1);
        #1 hold_n_io3_in = 1'b1;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) #1 program_active = (k == 0);
            erase_active = (k == 1);
            suspend_req = 1'b1;
            @(posedge clk) #1 suspend_req = 1'b0;
            rd(8'h48, 8'h12 | (8'h04 << k));
            #1 resume_req = 1'b1;
            @(posedge clk) #1 resume_req = 1'b0;
            rd(8'h48, 8'h12);
        end
        complete_run;
    end
endmodule
